//--- logic/comm_supervisor.sv
// Fieldbus communication supervisor with APB settings registers
`timescale 1ns/10ps
`default_nettype none
module comm_supervisor #(
    parameter int unsigned STEP_CYCLES_P = fieldbus_pkg::STEP_CYCLES
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      srst,
    // APB slave
    input  wire fieldbus_pkg::apb_req_type apb_req,
    output fieldbus_pkg::apb_rsp_type      apb_rsp,
    // Link events from the frame receiver, and the option-fitted flag
    input  wire logic                      frame_ok,
    input  wire logic                      frame_err,
    input  wire logic                      option_is_link,
    // Drive side
    input  wire logic                      fault_reset,
    output fieldbus_pkg::sup_type          sup_q,
    output fieldbus_pkg::cfg_type          cfg_q
);
    import fieldbus_pkg::*;

    // Settings held by software
    cfg_type    set_q;        // Stored settings
    cfg_type    set_d;
    logic [1:0] mode_q;       // error_detect_mode
    logic [1:0] mode_d;
    logic [1:0] action_q;     // error_action_select
    logic [1:0] action_d;
    logic       cmdsel_q;     // network_command_select
    logic       cmdsel_d;
    // Bus answer
    apb_rsp_type rsp_d;
    logic        wr_en;       // Write takes effect this edge
    logic        rd_go;       // Answer is built this cycle
    // Watchdog
    watch_type  st_q;
    watch_type  st_d;
    logic [6:0] elapsed_q;    // Steps since last good frame
    logic [6:0] elapsed_d;
    logic       expire_q;     // One-cycle timeout event
    logic       expire_d;
    logic       tick;
    logic       err_ev;       // Any transmission error
    // Supervisor and effective config
    sup_type    sup_d;
    cfg_type    cfg_d;

    // Step divider, realigned by each good frame
    step_divider #(
        .CYCLES  (STEP_CYCLES_P)
    ) u_step (
        .clock   (clock),
        .srst    (srst),
        .restart (frame_ok),
        .tick_q  (tick)
    );

    // One wait state: pready rises in the second access cycle
    assign rd_go = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    assign wr_en = apb_req.psel && apb_req.penable && apb_rsp.pready
                   && apb_req.pwrite;

    // Bus answer, data and error computed once per transfer
    always_comb
    begin
        rsp_d        = '0;
        rsp_d.pready = rd_go;
        if (rd_go)
        begin
            case (apb_req.paddr)
                OFS_STATION:
                    rsp_d.prdata = 32'(set_q.station);
                OFS_ERRCFG:
                    rsp_d.prdata = (32'(mode_q) << POS_MODE)
                                 | (32'(action_q) << POS_ACTION)
                                 | (32'(cmdsel_q) << POS_CMDSEL);
                OFS_TIMEOUT:
                    rsp_d.prdata = 32'(set_q.timeout);
                OFS_LINKCFG:
                    rsp_d.prdata = (32'(set_q.bit_rate) << POS_RATE)
                                 | (32'(set_q.xfer_size) << POS_SIZE)
                                 | (32'(set_q.proto_ver) << POS_VER)
                                 | (32'(set_q.data_range) << POS_RANGE);
                OFS_STATUS:
                    rsp_d.prdata = {9'h000, elapsed_q, 7'h00,
                                    st_q, sup_q};
                default:
                    rsp_d.pslverr = 1'b1; // Unmapped address
            endcase
        end
    end

    // Settings writes; out-of-range values leave the field unchanged
    always_comb
    begin
        set_d    = set_q;
        mode_d   = mode_q;
        action_d = action_q;
        cmdsel_d = cmdsel_q;
        if (wr_en)
        begin
            case (apb_req.paddr)
                OFS_STATION:
                    if (apb_req.pwdata[6:0] <= STATION_MAX)
                    begin
                        set_d.station = apb_req.pwdata[6:0];
                    end
                OFS_ERRCFG:
                begin
                    // Mode 0 is not a legal code
                    if (apb_req.pwdata[POS_MODE +: 2] != 2'h0)
                    begin
                        mode_d = apb_req.pwdata[POS_MODE +: 2];
                    end
                    if (apb_req.pwdata[POS_ACTION +: 2] <= ACT_STOP)
                    begin
                        action_d = apb_req.pwdata[POS_ACTION +: 2];
                    end
                    cmdsel_d = apb_req.pwdata[POS_CMDSEL];
                end
                OFS_TIMEOUT:
                    if (apb_req.pwdata[6:0] <= TMO_MAX)
                    begin
                        set_d.timeout = apb_req.pwdata[6:0];
                    end
                OFS_LINKCFG:
                begin
                    if (apb_req.pwdata[POS_RATE +: 3] != 3'h0 &&
                        apb_req.pwdata[POS_RATE +: 3] <= RATE_MAX)
                    begin
                        set_d.bit_rate = apb_req.pwdata[POS_RATE +: 3];
                    end
                    if (apb_req.pwdata[POS_SIZE +: 2] == 2'h1 ||
                        apb_req.pwdata[POS_SIZE +: 2] == 2'h2)
                    begin
                        set_d.xfer_size = apb_req.pwdata[POS_SIZE +: 2];
                    end
                    if (apb_req.pwdata[POS_VER +: 2] == 2'h1 ||
                        apb_req.pwdata[POS_VER +: 2] == 2'h2)
                    begin
                        set_d.proto_ver = apb_req.pwdata[POS_VER +: 2];
                    end
                    if (apb_req.pwdata[POS_RANGE +: 4] <= RANGE_MAX)
                    begin
                        set_d.data_range = apb_req.pwdata[POS_RANGE +: 4];
                    end
                end
                default:
                    set_d = set_q; // Read-only or unmapped
            endcase
        end
    end

    // Effective link config; link-only codes fall back when not fitted
    always_comb
    begin
        cfg_d = set_q;
        if (!option_is_link)
        begin
            cfg_d.bit_rate  = RATE_RST;
            cfg_d.xfer_size = SIZE_RST;
            cfg_d.proto_ver = VER_RST;
        end
    end

    // Master watch; timeout 0 disables it, first frame arms it
    always_comb
    begin
        st_d      = st_q;
        elapsed_d = elapsed_q;
        expire_d  = 1'b0;
        case (st_q)
            ST_IDLE:
                if (frame_ok)
                begin
                    st_d      = ST_WATCH;
                    elapsed_d = '0;
                end
            ST_WATCH:
                if (frame_ok)
                begin
                    elapsed_d = '0;
                end
                else if (tick && set_q.timeout != 7'h00)
                begin
                    elapsed_d = elapsed_q + 7'h01;
                    if (elapsed_d >= set_q.timeout)
                    begin
                        st_d     = ST_EXPIRED;
                        expire_d = 1'b1;
                    end
                end
            ST_EXPIRED:
                if (frame_ok)
                begin
                    st_d      = ST_WATCH;
                    elapsed_d = '0;
                end
            default:
                st_d = ST_IDLE;
        endcase
    end

    assign err_ev = frame_err || expire_q;

    // Supervisor flags; a new error wins over a same-cycle fault reset
    always_comb
    begin
        sup_d                 = sup_q;
        sup_d.wipe_set_values = 1'b0;
        if (fault_reset)
        begin
            sup_d = '0;
        end
        // Mode 1 or command off falls through untouched
        if (err_ev && cmdsel_q)
        begin
            case (mode_q)
                MODE_FAULT:
                    sup_d.fault_code = frame_err ? CODE_LINK : CODE_TMO;
                MODE_MINOR:
                begin
                    sup_d.minor_fault = 1'b1;
                    case (action_q)
                        ACT_HOLD: sup_d.hold_values     = 1'b1;
                        ACT_WIPE: sup_d.wipe_set_values = 1'b1;
                        ACT_STOP: sup_d.emergency_stop  = 1'b1;
                        default:  sup_d.hold_values     = 1'b1;
                    endcase
                end
                default:
                    sup_d.minor_fault = sup_d.minor_fault;
            endcase
        end
    end

    // All state registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            set_q     <= '{STATION_RST, RATE_RST, SIZE_RST, VER_RST,
                           RANGE_RST, TMO_RST};
            cfg_q     <= '{STATION_RST, RATE_RST, SIZE_RST, VER_RST,
                           RANGE_RST, TMO_RST};
            mode_q    <= MODE_NONE;
            action_q  <= ACT_HOLD;
            cmdsel_q  <= 1'b0;
            apb_rsp   <= '0;
            st_q      <= ST_IDLE;
            elapsed_q <= '0;
            expire_q  <= 1'b0;
            sup_q     <= '0;
        end
        else
        begin
            set_q     <= set_d;
            cfg_q     <= cfg_d;
            mode_q    <= mode_d;
            action_q  <= action_d;
            cmdsel_q  <= cmdsel_d;
            apb_rsp   <= rsp_d;
            st_q      <= st_d;
            elapsed_q <= elapsed_d;
            expire_q  <= expire_d;
            sup_q     <= sup_d;
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_quiet;
        err_ev && (!cmdsel_q || mode_q == MODE_NONE) && !fault_reset
        |=> $stable(sup_q);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("error acted on while detection off");

    property p_fault_code;
        err_ev && cmdsel_q && mode_q == MODE_FAULT
        |=> sup_q.fault_code != CODE_NONE && !sup_q.minor_fault
            || $past(sup_q.minor_fault);
    endproperty
    a_fault_code: assert property (p_fault_code)
        else $error("no fault code after error in mode 2");

    property p_minor;
        err_ev && cmdsel_q && mode_q == MODE_MINOR |=> sup_q.minor_fault;
    endproperty
    a_minor: assert property (p_minor)
        else $error("no minor fault after error in mode 3");

    property p_wipe;
        err_ev && cmdsel_q && mode_q == MODE_MINOR && action_q == ACT_WIPE
        |=> sup_q.wipe_set_values ##1 !sup_q.wipe_set_values || $past(err_ev);
    endproperty
    a_wipe: assert property (p_wipe)
        else $error("wipe pulse missing or too long");

    property p_stop;
        err_ev && cmdsel_q && mode_q == MODE_MINOR && action_q == ACT_STOP
        |=> sup_q.emergency_stop && !$rose(sup_q.hold_values);
    endproperty
    a_stop: assert property (p_stop)
        else $error("no emergency stop after error");

    property p_stop_held;
        sup_q.emergency_stop && !fault_reset |=> sup_q.emergency_stop;
    endproperty
    a_stop_held: assert property (p_stop_held)
        else $error("emergency stop dropped without fault reset");

    property p_expire;
        expire_q |-> st_q == ST_EXPIRED && elapsed_q == set_q.timeout
                     && set_q.timeout != 7'h00;
    endproperty
    a_expire: assert property (p_expire)
        else $error("timeout event at wrong step count");

    property p_limits;
        set_q.timeout <= TMO_MAX && set_q.station <= STATION_MAX
        && set_q.data_range <= RANGE_MAX && set_q.bit_rate != 3'h0;
    endproperty
    a_limits: assert property (p_limits)
        else $error("setting outside its legal range");

    property p_apb_answer;
        apb_req.psel && apb_req.penable && !apb_rsp.pready
        |=> apb_rsp.pready ##1 !apb_rsp.pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB answer not one wait state");

    c_fault: cover property (err_ev && cmdsel_q && mode_q == MODE_FAULT);
    c_stop: cover property (sup_q.emergency_stop ##1 fault_reset);
    c_expire: cover property (st_q == ST_WATCH ##1 expire_q);
endmodule
`default_nettype wire

//--- inc/fieldbus_pkg.sv
// Package: constants, types and register map of the comm supervisor
`default_nettype none
package fieldbus_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STEP_TIME_NS  = 100_000_000; // 0.1 s
    localparam int unsigned STEP_CYCLES   = STEP_TIME_NS / CLK_PERIOD_NS;
    // Register offsets
    localparam logic [7:0] OFS_STATION = 8'h00;
    localparam logic [7:0] OFS_ERRCFG  = 8'h04;
    localparam logic [7:0] OFS_TIMEOUT = 8'h08;
    localparam logic [7:0] OFS_LINKCFG = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    // Field positions
    localparam int unsigned POS_MODE   = 0;
    localparam int unsigned POS_ACTION = 4;
    localparam int unsigned POS_CMDSEL = 8;
    localparam int unsigned POS_RATE   = 0;
    localparam int unsigned POS_SIZE   = 4;
    localparam int unsigned POS_VER    = 8;
    localparam int unsigned POS_RANGE  = 16;
    // Reset values and limits
    localparam logic [6:0] STATION_RST = 7'h01;
    localparam logic [6:0] STATION_MAX = 7'h7e;
    localparam logic [6:0] TMO_RST     = 7'h32;
    localparam logic [6:0] TMO_MAX     = 7'h64;
    localparam logic [2:0] RATE_RST    = 3'h1;
    localparam logic [2:0] RATE_MAX    = 3'h4;
    localparam logic [1:0] SIZE_RST    = 2'h1;
    localparam logic [1:0] VER_RST     = 2'h1;
    localparam logic [3:0] RANGE_RST   = 4'h0;
    localparam logic [3:0] RANGE_MAX   = 4'hb;
    // Error detection modes and actions
    localparam logic [1:0] MODE_NONE   = 2'h1;
    localparam logic [1:0] MODE_FAULT  = 2'h2;
    localparam logic [1:0] MODE_MINOR  = 2'h3;
    localparam logic [1:0] ACT_HOLD    = 2'h0;
    localparam logic [1:0] ACT_WIPE    = 2'h1;
    localparam logic [1:0] ACT_STOP    = 2'h2;
    // Fault codes
    localparam logic [1:0] CODE_NONE   = 2'h0;
    localparam logic [1:0] CODE_LINK   = 2'h1;
    localparam logic [1:0] CODE_TMO    = 2'h2;

    // Master watch states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_WATCH   = 3'b010,
        ST_EXPIRED = 3'b100
    } watch_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    typedef struct packed {
        logic [6:0] station;
        logic [2:0] bit_rate;
        logic [1:0] xfer_size;
        logic [1:0] proto_ver;
        logic [3:0] data_range;
        logic [6:0] timeout;
    } cfg_type;

    typedef struct packed {
        logic [1:0] fault_code;
        logic       minor_fault;
        logic       hold_values;
        logic       wipe_set_values;
        logic       emergency_stop;
    } sup_type;
endpackage
`default_nettype wire

//--- logic/step_divider.sv
// Divider producing a one-cycle pulse every supervision step
`timescale 1ns/10ps
`default_nettype none
module step_divider #(
    parameter int unsigned CYCLES = 10
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Control
    input  wire logic restart,
    // Step pulse
    output logic      tick_q
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;  // Cycles into this step
    logic [CW-1:0] cnt_d;
    logic          tick_d;

    // Restart aligns steps to the last frame, so timing is exact
    always_comb
    begin
        cnt_d  = cnt_q + CW'(1);
        tick_d = 1'b0;
        if (restart)
        begin
            cnt_d = '0;
        end
        else if (cnt_q == CW'(CYCLES - 1))
        begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    // Tick is one cycle wide
    property p_tick_single;
        @(posedge clock) disable iff (srst) tick_q |=> !tick_q;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("step tick wider than one cycle");
endmodule
`default_nettype wire

//--- test/master_station.sv
// Behavioural fieldbus master station producing frame events
`timescale 1ns/10ps
`default_nettype none
module master_station #(
    parameter int unsigned GAP     = 4, // Cycles between good frames
    parameter int unsigned STATION = 2  // Remote address, 02..31
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Bench control
    input  wire logic run,
    input  wire logic corrupt,
    // Frame events toward the supervisor
    output logic      frame_ok,
    output logic      frame_err
);
    logic [7:0] gap_q; // Frame spacing counter
    // Good frames only while running; a corrupt request spoils one frame
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            gap_q     <= 8'h00;
            frame_ok  <= 1'b0;
            frame_err <= 1'b0;
        end
        else
        begin
            frame_err <= corrupt;
            frame_ok  <= run && !corrupt && gap_q == 8'(GAP - 1);
            gap_q     <= (run && gap_q != 8'(GAP - 1)) ? gap_q + 8'h01 : 8'h00;
        end
    end
endmodule
`default_nettype wire

//--- test/test_comm_supervisor.sv
// Testbench for the fieldbus communication supervisor
`timescale 1ns/10ps
`default_nettype none
module test_comm_supervisor;
    import fieldbus_pkg::*;
    logic        clock;          // 100 MHz clock
    logic        srst;           // Synchronous reset
    apb_req_type req;            // APB request
    apb_rsp_type rsp;            // APB response
    logic        frame_ok;       // Good frame from partner
    logic        frame_err;      // Bad frame from partner
    logic        option_is_link; // Option fitted
    logic        fault_reset;    // Drive fault reset
    logic        run;            // Partner sends frames
    logic        corrupt;        // Partner spoils a frame
    sup_type     sup_q;          // Supervisor outputs
    cfg_type     cfg_q;          // Effective settings
    int          err_total;      // Mismatches
    int          checked;        // Comparisons
    int          wipes;          // Wipe pulses seen
    logic [31:0] q;              // Read data
    logic        e;              // Slave error
    // Short step so timeouts take tens of cycles
    comm_supervisor #(.STEP_CYCLES_P(10)) u_comm_supervisor (
        .clock(clock), .srst(srst), .apb_req(req), .apb_rsp(rsp),
        .frame_ok(frame_ok), .frame_err(frame_err),
        .option_is_link(option_is_link), .fault_reset(fault_reset),
        .sup_q(sup_q), .cfg_q(cfg_q));
    master_station #(.GAP(4)) u_master_station (
        .clock(clock), .srst(srst), .run(run), .corrupt(corrupt),
        .frame_ok(frame_ok), .frame_err(frame_err));
    // Clock generator
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Count wipe pulses; a level instead of a pulse counts many
    always @(posedge clock)
    begin
        if (sup_q.wipe_set_values === 1'b1)
            wipes = wipes + 1;
    end
    // Compare and count
    task check(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One APB transfer; only the watchdog ends a wait for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // Read and compare one register
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check("read data", x, q);
    endtask
    // Synchronous reset held four cycles
    task reset_dut();
        srst <= 1'b1;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
    endtask
    // Verdict; also reached by the watchdog
    task summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize();
    end
    // Error cases: {cmd, mode, action, expected sup_q, expected wipes}
    logic [13:0] cases [7] = '{
        {1'b0, 2'h2, 2'h0, 6'h00, 3'h0}, {1'b0, 2'h3, 2'h2, 6'h00, 3'h0},
        {1'b1, 2'h1, 2'h2, 6'h00, 3'h0}, {1'b1, 2'h2, 2'h0, 6'h10, 3'h0},
        {1'b1, 2'h3, 2'h0, 6'h0c, 3'h0}, {1'b1, 2'h3, 2'h1, 6'h08, 3'h1},
        {1'b1, 2'h3, 2'h2, 6'h09, 3'h0}};
    // Main sequence
    initial
    begin
        {srst, req, option_is_link, fault_reset, run, corrupt} = '0;
        srst = 1'b1;
        option_is_link = 1'b1;
        err_total = 0;
        checked = 0;
        wipes = 0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        // Reset values
        rd(OFS_STATION, 32'h1);
        rd(OFS_ERRCFG, 32'h1);
        rd(OFS_TIMEOUT, 32'h32);
        rd(OFS_LINKCFG, 32'h111);
        // Limits: in-range kept, out-of-range ignored
        apb(1'b1, OFS_STATION, 32'h7e);
        apb(1'b1, OFS_STATION, 32'h7f);
        rd(OFS_STATION, 32'h7e);
        apb(1'b1, OFS_TIMEOUT, 32'h64);
        apb(1'b1, OFS_TIMEOUT, 32'h65);
        rd(OFS_TIMEOUT, 32'h64);
        apb(1'b1, OFS_LINKCFG, 32'h000b0224);
        apb(1'b1, OFS_LINKCFG, 32'h000c0225);
        rd(OFS_LINKCFG, 32'h000b0224);
        // Every bit-rate code 1..4 reaches the effective settings
        for (int r = 1; r <= 4; r++)
        begin
            apb(1'b1, OFS_LINKCFG, 32'(r) | 32'h000b0220);
            repeat (2) @(posedge clock);
            check("bit rate", 32'(r), 32'(cfg_q.bit_rate));
        end
        // Other option fitted: link-only settings fall back
        option_is_link <= 1'b0;
        repeat (3) @(posedge clock);
        check("rate off", 32'h1, 32'(cfg_q.bit_rate));
        check("size off", 32'h1, 32'(cfg_q.xfer_size));
        check("ver off", 32'h1, 32'(cfg_q.proto_ver));
        check("range", 32'hb, 32'(cfg_q.data_range));
        check("station", 32'h7e, 32'(cfg_q.station));
        check("tmo cfg", 32'h64, 32'(cfg_q.timeout));
        option_is_link <= 1'b1;
        // Unmapped address is refused
        apb(1'b1, 8'h20, 32'h5);
        check("slave error", 32'h1, 32'(e));
        // Transmission error under each mode and action
        foreach (cases[i])
        begin
            reset_dut();
            apb(1'b1, OFS_ERRCFG, {23'h0, cases[i][13], 2'h0,
                cases[i][10:9], 2'h0, cases[i][12:11]});
            wipes = 0;
            corrupt <= 1'b1;
            @(posedge clock);
            corrupt <= 1'b0;
            repeat (6) @(posedge clock);
            check("flags", 32'(cases[i][8:3]), 32'(sup_q));
            check("wipes", 32'(cases[i][2:0]), 32'(wipes));
        end
        // Stop stays until fault reset
        repeat (20) @(posedge clock);
        check("stop held", 32'h1, 32'(sup_q.emergency_stop));
        fault_reset <= 1'b1;
        @(posedge clock);
        fault_reset <= 1'b0;
        repeat (3) @(posedge clock);
        check("stop clear", 32'h0, 32'(sup_q.emergency_stop));
        // Master silence: 2 steps of 10 cycles
        reset_dut();
        apb(1'b1, OFS_ERRCFG, 32'h102);
        apb(1'b1, OFS_TIMEOUT, 32'h2);
        run <= 1'b1;
        repeat (60) @(posedge clock);
        check("alive", 32'h0, 32'(sup_q.fault_code));
        run <= 1'b0;
        repeat (12) @(posedge clock);
        check("early", 32'h0, 32'(sup_q.fault_code));
        repeat (30) @(posedge clock);
        check("timeout", 32'(CODE_TMO), 32'(sup_q.fault_code));
        rd(OFS_STATUS, 32'h00020120);
        summarize();
    end
endmodule
`default_nettype wire
